// File: rtl/sms_pkg.sv
// package: register map, field positions and types of the serial port
package sms_pkg;
   // ---------------------------------------------------------------
   // special function register addresses
   // ---------------------------------------------------------------
   localparam logic [7:0] SFR_TX_BUF = 8'h9a;
   localparam logic [7:0] SFR_RX_BUF = 8'h9b;
   localparam logic [7:0] SFR_CFG_ONE = 8'he8;
   localparam logic [7:0] SFR_CFG_TWO = 8'he9;
   localparam logic [7:0] SFR_STATUS = 8'hea;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_CFG_ONE = 8'h00;
   localparam logic [7:0] RST_CFG_TWO = 8'h00;
   localparam logic [7:0] RST_BYTE = 8'h00;

   // ---------------------------------------------------------------
   // serial_config_one fields
   // ---------------------------------------------------------------
   localparam int C1_MASTER = 6;
   localparam int C1_TIMING_SEL = 5;
   localparam int C1_AUTO_SS = 4;
   localparam int C1_SS_IN_EN = 3;
   localparam int C1_OVF_OVERWRITE = 2;
   localparam int C1_RATE_LSB = 0;
   localparam int RATE_W = 2;

   // ---------------------------------------------------------------
   // serial_config_two fields
   // ---------------------------------------------------------------
   localparam int C2_CONTINUOUS = 7;
   localparam int C2_CLOCK_POLARITY = 3;
   localparam int C2_CLOCK_PHASE = 2;
   localparam int C2_IRQ_EN = 1;

   // ---------------------------------------------------------------
   // serial_port_status fields
   // ---------------------------------------------------------------
   localparam int ST_BUSY = 7;
   localparam int ST_MULTIMASTER_ERR = 6;
   localparam int ST_RX_OVERFLOW = 5;
   localparam int ST_RX_IRQ = 4;
   localparam int ST_RX_FULL = 3;
   localparam int ST_TX_UNDERFLOW = 2;
   localparam int ST_TX_IRQ = 1;
   localparam int ST_TX_FULL = 0;

   // ---------------------------------------------------------------
   // timing: clock edges per byte and divider width
   // ---------------------------------------------------------------
   localparam logic [3:0] LAST_EDGE = 4'hf;
   localparam int DIV_W = 5;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } sms_sfr_req_t;

   typedef struct packed {
      logic sclk;
      logic mosi;
      logic ss_n;
   } sms_pin_t;

   typedef enum logic [3:0] {
      MS_IDLE = 4'b0001,
      MS_LEAD = 4'b0010,
      MS_XFER = 4'b0100,
      MS_GAP = 4'b1000
   } sms_mst_state_t;
endpackage : sms_pkg

// File: rtl/sms_sync.sv
// module: two flip-flop level synchroniser with a reset value
`timescale 1ns/1ps
module sms_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_ff;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         meta_ff <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta_ff <= d;
         q <= meta_ff;
      end
   end
endmodule : sms_sync

// File: rtl/sms_spi_port.sv
// module: double-buffered byte-wide serial port, master or slave
`timescale 1ns/1ps
// How it works
// - rx irq flag sets on new received byte; reading receive buffer clears it
// - timing select 0: unread receive buffer at byte end stops transfer
// - interrupt request follows rx or tx irq flags when enabled
// - rx full bit sets with new byte, cleared by reading receive buffer
// - tx underflow sets when a byte finds no data; write 0 clears
// - tx irq flag sets when buffer empties; write to buffer clears
// - timing select 1: unwritten transmit buffer at byte end stops transfer
// - tx full bit sets on buffer write; write 0 clears it
// - miso is input as master and driven output as slave while select is low
// - mosi is driven output as master and input as slave
// - data moves in eight-bit bytes, most significant bit first
// - serial clock is output as master and input as slave
// - master clock rate, polarity and phase come from both config registers
// - launch on one clock edge, sample on the other; modes must match
// - slave transfers run while select is held low; select is input
// - auto select drives select low for transfer, high once done
// - multimaster: select is an input, slave selects come from gpio
// - continuous mode streams bytes until transmit buffer is empty or, with timing select 0, rx is unread
// - continuous clear: one byte per transfer, chosen automatically
// - unread byte at next completion sets overflow; overwrite or discard
// - select input low during master transfer raises multimaster error
module sms_spi_port (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // special function register port
   input wire sms_pkg::sms_sfr_req_t sfr_req,
   output logic [7:0] sfr_rdata,
   // serial link inputs
   input wire logic link_sclk,
   input wire logic mosi_i,
   input wire logic miso_i,
   input wire logic ss_n_i,
   // serial link outputs
   output sms_pkg::sms_pin_t pin_o,
   output sms_pkg::sms_pin_t pin_oe,
   output logic miso_o,
   output logic miso_oe,
   // interrupt
   output logic irq_o
);
   import sms_pkg::*;

   // ---------------------------------------------------------------
   // registers and flags
   // ---------------------------------------------------------------
   logic [7:0] cfg1_ff, cfg2_ff, tx_buf_ff, rx_buf_ff, rdata_ff, slv_tx_ff;
   logic rx_irq_ff, rx_full_ff, rx_of_ff, tx_uf_ff, tx_irq_ff, tx_full_ff;
   logic mm_err_ff, irq_ff;
   sms_mst_state_t state_ff;
   logic [3:0] edge_ff;
   logic [DIV_W-1:0] div_ff;
   logic sclk_ff, mosi_ff, ss_ff;
   logic [7:0] tx_sh_ff, rx_sh_ff;
   sms_pin_t oe_ff;
   logic miso_oe_ff, ss_prev_ff, tgl_seen_ff, slv_inv_ff;

   // synchronised pins and slave events
   logic ss_s, miso_s, tgl_s;
   logic l_tgl_ff;

   logic is_master, cpol, cpha, cont, timing_sel, tick;
   logic wr_tx, wr_stat, rd_rx, mst_end, mst_go, mst_load;
   logic slv_start, slv_done, slv_load, slv_empty, rx_evt;
   logic [7:0] mst_byte, rx_byte, l_rx_byte_ff;
   logic [7:0] status;

   assign is_master = cfg1_ff[C1_MASTER];
   assign cpol = cfg2_ff[C2_CLOCK_POLARITY];
   assign cpha = cfg2_ff[C2_CLOCK_PHASE];
   assign cont = cfg2_ff[C2_CONTINUOUS];
   assign timing_sel = cfg1_ff[C1_TIMING_SEL];
   assign wr_tx = sfr_req.wr && sfr_req.addr == SFR_TX_BUF;
   assign wr_stat = sfr_req.wr && sfr_req.addr == SFR_STATUS;
   assign rd_rx = sfr_req.rd && sfr_req.addr == SFR_RX_BUF;

   // half period of the master clock (4 << rate core clocks), minus one;
   // a returned miso bit needs three core edges through the synchroniser,
   // so a two-clock half period would sample it one bit stale
   // at the slowest rate the shift wraps to zero and the minus one gives
   // the full count of the divider
   function automatic logic [DIV_W-1:0] half_limit(
      input logic [RATE_W-1:0] rate);
      logic [DIV_W-1:0] one;
      one = {{(DIV_W-1){1'b0}}, 1'b1};
      half_limit = (DIV_W'(4) << rate) - one;
   endfunction : half_limit

   assign tick = div_ff == half_limit(cfg1_ff[C1_RATE_LSB +: RATE_W]);

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   sms_sync #(.W(3), .RST_VAL(3'b100)) u_sync (
      .clk(clk),
      .rstn(rstn),
      .d({ss_n_i, miso_i, l_tgl_ff}),
      .q({ss_s, miso_s, tgl_s})
   );

   // ---------------------------------------------------------------
   // slave link domain
   // ---------------------------------------------------------------
   // the effective clock rises on every sampling edge; the inversion
   // is quasi-static because polarity and phase are set before select
   logic slv_clk;
   logic [2:0] l_cnt_ff;
   logic [6:0] l_sh_ff;
   logic l_out_ff;
   assign slv_clk = link_sclk ^ slv_inv_ff;

   // bit counter restarts whenever the external master releases select
   always_ff @(posedge slv_clk or posedge ss_n_i) begin
      if (ss_n_i) begin
         l_cnt_ff <= 3'h0;
         l_sh_ff <= 7'h00;
      end else begin
         l_cnt_ff <= l_cnt_ff + 3'h1;
         l_sh_ff <= {l_sh_ff[5:0], mosi_i};
      end
   end

   // byte hand-off: word held stable, event crosses as a toggle
   always_ff @(posedge slv_clk or negedge rstn) begin
      if (!rstn) begin
         l_rx_byte_ff <= RST_BYTE;
         l_tgl_ff <= 1'b0;
      end else if (l_cnt_ff == 3'h7 && !ss_n_i) begin
         l_rx_byte_ff <= {l_sh_ff, mosi_i};
         l_tgl_ff <= ~l_tgl_ff;
      end
   end

   // launch edge: next bit of the slave transmit word, msb first
   always_ff @(negedge slv_clk or posedge ss_n_i) begin
      if (ss_n_i) begin
         l_out_ff <= 1'b0;
      end else begin
         l_out_ff <= slv_tx_ff[~l_cnt_ff];
      end
   end

   // first bit must stand before the first sampling edge
   assign miso_o = (l_cnt_ff == 3'h0) ? slv_tx_ff[7] : l_out_ff;

   // ---------------------------------------------------------------
   // slave events in the core domain
   // ---------------------------------------------------------------
   assign slv_start = !is_master && ss_prev_ff && !ss_s;
   assign slv_done = !is_master && (tgl_s != tgl_seen_ff);
   assign slv_load = (slv_start || slv_done) && tx_full_ff;
   assign slv_empty = (slv_start || slv_done) && !tx_full_ff;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         ss_prev_ff <= 1'b1;
         tgl_seen_ff <= 1'b0;
         slv_tx_ff <= RST_BYTE;
         slv_inv_ff <= 1'b0;
         miso_oe_ff <= 1'b0;
      end else begin
         ss_prev_ff <= ss_s;
         tgl_seen_ff <= tgl_s;
         slv_inv_ff <= cpol ^ cpha;
         miso_oe_ff <= !is_master && !ss_s;
         if (slv_load) begin
            slv_tx_ff <= tx_buf_ff;
         end
      end
   end

   // ---------------------------------------------------------------
   // master sequencer
   // ---------------------------------------------------------------
   assign mst_end = state_ff == MS_XFER && tick && edge_ff == LAST_EDGE;
   assign mst_byte = cpha ? {rx_sh_ff[6:0], miso_s} : rx_sh_ff;
   // the transmit buffer, and with timing select 0 the receive buffer, decide whether another byte may start
   assign mst_go = cont && tx_full_ff
      && !(!timing_sel && rx_irq_ff);
   assign mst_load = (state_ff == MS_IDLE && is_master && tx_full_ff)
      || (mst_end && mst_go);

   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_ff <= MS_IDLE;
         edge_ff <= 4'h0;
         div_ff <= '0;
         sclk_ff <= 1'b0;
         mosi_ff <= 1'b0;
         ss_ff <= 1'b1;
         tx_sh_ff <= RST_BYTE;
         rx_sh_ff <= RST_BYTE;
      end else begin
         case (state_ff)
            MS_IDLE: begin
               sclk_ff <= cpol;
               div_ff <= '0;
               edge_ff <= 4'h0;
               if (is_master && tx_full_ff) begin
                  state_ff <= MS_LEAD;
                  ss_ff <= 1'b0;
               end
            end
            MS_LEAD: begin
               div_ff <= tick ? '0 : div_ff + 1'b1;
               if (tick) begin
                  state_ff <= MS_XFER;
               end
            end
            MS_XFER: begin
               div_ff <= tick ? '0 : div_ff + 1'b1;
               if (tick) begin
                  sclk_ff <= ~sclk_ff;
                  edge_ff <= edge_ff + 4'h1;
                  if (edge_ff[0] == cpha) begin
                     rx_sh_ff <= {rx_sh_ff[6:0], miso_s};
                  end else begin
                     mosi_ff <= tx_sh_ff[7];
                     tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
                  end
                  if (edge_ff == LAST_EDGE && !mst_go) begin
                     state_ff <= MS_GAP;
                     ss_ff <= 1'b1;
                  end
               end
            end
            MS_GAP: begin
               sclk_ff <= cpol;
               div_ff <= tick ? '0 : div_ff + 1'b1;
               if (tick) begin
                  state_ff <= MS_IDLE;
               end
            end
            default: begin
               state_ff <= MS_IDLE;
               ss_ff <= 1'b1;
            end
         endcase
         // a load overrides the launch so the next msb is ready in time
         if (mst_load) begin
            mosi_ff <= tx_buf_ff[7];
            tx_sh_ff <= cpha ? tx_buf_ff : {tx_buf_ff[6:0], 1'b0};
         end
      end
   end

   // ---------------------------------------------------------------
   // configuration registers and pin directions
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cfg1_ff <= RST_CFG_ONE;
         cfg2_ff <= RST_CFG_TWO;
         oe_ff <= '0;
      end else begin
         if (sfr_req.wr && sfr_req.addr == SFR_CFG_ONE) begin
            cfg1_ff <= sfr_req.wdata;
         end
         if (sfr_req.wr && sfr_req.addr == SFR_CFG_TWO) begin
            cfg2_ff <= sfr_req.wdata;
         end
         oe_ff.sclk <= is_master;
         oe_ff.mosi <= is_master;
         // with select input on, gpio pins drive the slave selects
         oe_ff.ss_n <= is_master && cfg1_ff[C1_AUTO_SS]
            && !cfg1_ff[C1_SS_IN_EN];
      end
   end

   // ---------------------------------------------------------------
   // receive buffer and flags
   // ---------------------------------------------------------------
   assign rx_evt = mst_end || slv_done;
   assign rx_byte = mst_end ? mst_byte : l_rx_byte_ff;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         rx_buf_ff <= RST_BYTE;
         rx_irq_ff <= 1'b0;
         rx_full_ff <= 1'b0;
         rx_of_ff <= 1'b0;
      end else begin
         if (rd_rx) begin
            rx_irq_ff <= 1'b0;
            rx_full_ff <= 1'b0;
            rx_of_ff <= 1'b0;
         end
         // a read in the same cycle frees the buffer for the new byte
         if (rx_evt && rx_irq_ff && !rd_rx) begin
            rx_of_ff <= 1'b1;
            if (cfg1_ff[C1_OVF_OVERWRITE]) begin
               rx_buf_ff <= rx_byte;
            end
         end else if (rx_evt) begin
            rx_buf_ff <= rx_byte;
            rx_irq_ff <= 1'b1;
            rx_full_ff <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // transmit buffer and flags
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rstn) begin
         tx_buf_ff <= RST_BYTE;
         tx_full_ff <= 1'b0;
         tx_irq_ff <= 1'b0;
         tx_uf_ff <= 1'b0;
         mm_err_ff <= 1'b0;
      end else begin
         if (wr_stat && !sfr_req.wdata[ST_TX_UNDERFLOW]) begin
            tx_uf_ff <= 1'b0;
         end
         if (wr_stat && !sfr_req.wdata[ST_TX_IRQ]) begin
            tx_irq_ff <= 1'b0;
         end
         if (wr_stat && !sfr_req.wdata[ST_TX_FULL]) begin
            tx_full_ff <= 1'b0;
         end
         if (wr_stat && !sfr_req.wdata[ST_MULTIMASTER_ERR]) begin
            mm_err_ff <= 1'b0;
         end
         if (mst_load || slv_load) begin
            tx_full_ff <= 1'b0;
            tx_irq_ff <= 1'b1;
         end
         if ((mst_end && !tx_full_ff) || slv_empty) begin
            tx_uf_ff <= 1'b1;
         end
         // a fresh write keeps the buffer full, so it beats the load
         if (wr_tx) begin
            tx_buf_ff <= sfr_req.wdata;
            tx_full_ff <= 1'b1;
            tx_irq_ff <= 1'b0;
         end
         if (is_master && cfg1_ff[C1_SS_IN_EN] && !ss_s
            && state_ff == MS_XFER) begin
            mm_err_ff <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // status read-back, interrupt and outputs
   // ---------------------------------------------------------------
   always_comb begin
      status = 8'h00;
      status[ST_BUSY] = state_ff != MS_IDLE || (!is_master && !ss_s);
      status[ST_MULTIMASTER_ERR] = mm_err_ff;
      status[ST_RX_OVERFLOW] = rx_of_ff;
      status[ST_RX_IRQ] = rx_irq_ff;
      status[ST_RX_FULL] = rx_full_ff;
      status[ST_TX_UNDERFLOW] = tx_uf_ff;
      status[ST_TX_IRQ] = tx_irq_ff;
      status[ST_TX_FULL] = tx_full_ff;
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         rdata_ff <= 8'h00;
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= cfg2_ff[C2_IRQ_EN] && (rx_irq_ff || tx_irq_ff);
         if (sfr_req.rd) begin
            case (sfr_req.addr)
               SFR_RX_BUF: rdata_ff <= rx_buf_ff;
               SFR_CFG_ONE: rdata_ff <= cfg1_ff;
               SFR_CFG_TWO: rdata_ff <= cfg2_ff;
               SFR_STATUS: rdata_ff <= status;
               default: rdata_ff <= 8'h00;
            endcase
         end
      end
   end

   assign sfr_rdata = rdata_ff;
   assign irq_o = irq_ff;
   assign pin_o = '{sclk: sclk_ff, mosi: mosi_ff, ss_n: ss_ff};
   assign pin_oe = oe_ff;
   assign miso_oe = miso_oe_ff;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   a_rx_read_clear: assert property (
      rd_rx && !rx_evt |=> !rx_irq_ff && !rx_full_ff)
      else $error("rx flags not cleared by receive buffer read");
   a_rx_new_byte: assert property (
      rx_evt && !rx_irq_ff |=> rx_irq_ff && rx_full_ff
         && rx_buf_ff == $past(rx_byte))
      else $error("new byte not latched with flags");
   a_rx_overflow: assert property (
      rx_evt && rx_irq_ff && !rd_rx && !cfg1_ff[C1_OVF_OVERWRITE]
      |=> rx_of_ff && $stable(rx_buf_ff))
      else $error("overflow byte not discarded");
   a_tx_write_clear: assert property (
      wr_tx |=> tx_full_ff && !tx_irq_ff
         && tx_buf_ff == $past(sfr_req.wdata))
      else $error("transmit write did not fill buffer");
   a_irq_follow: assert property (
      cfg2_ff[C2_IRQ_EN] && (rx_irq_ff || tx_irq_ff) |=> irq_o)
      else $error("interrupt request missing");
   a_auto_select: assert property (
      state_ff == MS_XFER |-> !pin_o.ss_n)
      else $error("select high during master byte");
   a_stall_rx: assert property (
      mst_end && !timing_sel && rx_irq_ff |=> state_ff == MS_GAP
         ##1 pin_o.ss_n [*2])
      else $error("unread receive buffer did not stop transfer");
   a_stall_tx: assert property (
      mst_end && !tx_full_ff |=> state_ff == MS_GAP && pin_o.ss_n)
      else $error("empty transmit buffer did not stop transfer");
   a_pin_dirs: assert property (
      $rose(is_master) |=> pin_oe.mosi && pin_oe.sclk && !miso_oe)
      else $error("master pin directions wrong");
   a_mm_error: assert property (
      is_master && cfg1_ff[C1_SS_IN_EN] && !ss_s && state_ff == MS_XFER
      |=> mm_err_ff)
      else $error("multimaster error not raised");
   a_reset_flags: assert property (
      @(posedge clk) disable iff (1'b0)
      !rstn |=> status[6:0] == 7'h00 && !irq_o)
      else $error("flags not zero after reset");
endmodule : sms_spi_port

// File: testbench/sms_slave_model.sv
// far-side slave device model for master-mode transfers, mode 0
`timescale 1ns/1ps
module sms_slave_model (
   // link pins
   input wire logic sclk,
   input wire logic mosi,
   input wire logic ss_n,
   output logic miso,
   // byte it answers with and byte it saw
   input wire logic [7:0] tx_byte,
   output logic [7:0] rx_byte
);
   logic [7:0] sh = 8'h00;
   logic last = 1'b0;
   initial rx_byte = 8'h00;
   // ---------------------------------------------------------------
   // shifter: sample on rising, launch on falling
   // ---------------------------------------------------------------
   always @(negedge ss_n) sh = tx_byte;
   always @(posedge ss_n) last = sh[7];
   always @(posedge sclk) begin
      if (!ss_n) rx_byte = {rx_byte[6:0], mosi};
   end
   always @(negedge sclk) begin
      if (!ss_n) sh = {sh[6:0], ~sh[7]};
   end
   // released line shows the opposite of its last bit, never a stale copy
   assign miso = ss_n ? ~last : sh[7];
endmodule : sms_slave_model

// File: testbench/sms_spi_port_tb.sv
// self-checking bench of the serial port in master and slave roles
`timescale 1ns/1ps
module sms_spi_port_tb;
   import sms_pkg::*;
   logic clk = 1'b0, rstn = 1'b1, lclk = 1'b0, pend = 1'b0;
   logic tb_ss_n = 1'b1, tb_mosi = 1'b1;
   sms_sfr_req_t req = '0;
   sms_pin_t po, poe;
   logic [7:0] rdata, m_rx, m_tx, tb_byte, got;
   logic miso_o, miso_oe, irq, miso_w, sclk_w, mosi_w, ss_w;
   logic [31:0] seed = 32'ha37c9a70;
   logic [7:0] exq[$], mkq[$];
   int mismatches = 0, tests_run = 0, waited;
   always #5 clk = ~clk;
   assign sclk_w = poe.sclk ? po.sclk : lclk;
   assign mosi_w = poe.mosi ? po.mosi : tb_mosi;
   assign ss_w = poe.ss_n ? po.ss_n : tb_ss_n;
   sms_spi_port sms_spi_port_inst (.clk(clk), .rstn(rstn),
      .sfr_req(req), .sfr_rdata(rdata), .link_sclk(sclk_w),
      .mosi_i(mosi_w), .miso_i(miso_w), .ss_n_i(ss_w), .pin_o(po),
      .pin_oe(poe), .miso_o(miso_o), .miso_oe(miso_oe), .irq_o(irq));
   sms_slave_model sms_slave_model_inst (.sclk(sclk_w), .mosi(mosi_w),
      .ss_n(ss_w), .miso(miso_w), .tx_byte(m_tx), .rx_byte(m_rx));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [7:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[7:0];
   endfunction : rnd
   task automatic cmp(string n, logic [7:0] e, logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask : cmp
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(negedge clk);
      req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(negedge clk);
      req = '0;
   endtask : wr
   task automatic rd(logic [7:0] a, logic [7:0] e, logic [7:0] m);
      exq.push_back(e);
      mkq.push_back(m);
      @(negedge clk);
      req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(negedge clk);
      req = '0;
   endtask : rd
   task automatic wait_ss(logic lvl);
      for (waited = 0; waited < 400 && ss_w !== lvl; waited++) begin
         @(negedge clk);
      end
      cmp("select", {7'h0, lvl}, {7'h0, ss_w});
   endtask : wait_ss
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_of_test
   // read data lands one cycle after the strobe; oldest note is compared
   always @(posedge clk) begin
      if (pend) begin
         cmp("read data", exq[0], rdata & mkq[0]);
         void'(exq.pop_front());
         void'(mkq.pop_front());
      end
      pend <= req.rd;
   end
   initial begin
      #100000;
      mismatches++;
      end_of_test();
   end
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial begin
      // a real falling edge, so the link-side flops clear as well
      #1 rstn = 1'b0;
      repeat (3) @(negedge clk);
      rstn = 1'b1;
      rd(SFR_STATUS, 8'h00, 8'hff);
      rd(SFR_CFG_ONE, 8'h00, 8'hff);
      cmp("irq", 8'h00, {7'h0, irq});
      m_tx = rnd();
      tb_byte = rnd();
      wr(SFR_CFG_TWO, 8'h02);
      wr(SFR_CFG_ONE, 8'h50);
      wr(SFR_TX_BUF, tb_byte);
      wait_ss(1'b0);
      cmp("pin enables", 8'h07, {5'h0, poe});
      cmp("miso enable", 8'h00, {7'h0, miso_oe});
      wait_ss(1'b1);
      repeat (4) @(negedge clk);
      cmp("far rx", tb_byte, m_rx);
      cmp("irq", 8'h01, {7'h0, irq});
      rd(SFR_STATUS, 8'h1e, 8'hff);
      rd(SFR_RX_BUF, m_tx, 8'hff);
      rd(SFR_STATUS, 8'h06, 8'hff);
      wr(SFR_STATUS, 8'hfb);
      rd(SFR_STATUS, 8'h02, 8'hff);
      $display("test master byte done");
      // two streamed bytes paced by the transmit buffer, rx left unread
      m_tx = rnd();
      wr(SFR_CFG_TWO, 8'h82);
      wr(SFR_CFG_ONE, 8'h70);
      wr(SFR_TX_BUF, rnd());
      wait_ss(1'b0);
      tb_byte = rnd();
      wr(SFR_TX_BUF, tb_byte);
      wait_ss(1'b1);
      cmp("long frame", 8'h01, {7'h0, waited > 100});
      cmp("far rx", tb_byte, m_rx);
      rd(SFR_STATUS, 8'h20, 8'h20);
      rd(SFR_RX_BUF, m_tx, 8'hff);
      $display("test continuous done");
      // slave: bench acts as external master on a 30 ns link clock
      wr(SFR_CFG_ONE, 8'h00);
      wr(SFR_CFG_TWO, 8'h00);
      tb_byte = rnd();
      m_tx = rnd();
      wr(SFR_TX_BUF, tb_byte);
      #3 tb_ss_n = 1'b0;
      #100;
      cmp("miso enable", 8'h01, {7'h0, miso_oe});
      cmp("pin enables", 8'h00, {5'h0, poe});
      for (int b = 7; b >= 0; b--) begin
         tb_mosi = m_tx[b];
         #15 lclk = 1'b1;
         got[b] = miso_o;
         #15 lclk = 1'b0;
      end
      #100 tb_ss_n = 1'b1;
      tb_mosi = ~tb_mosi;
      cmp("slave tx", tb_byte, got);
      repeat (6) @(negedge clk);
      rd(SFR_STATUS, 8'h18, 8'h18);
      rd(SFR_RX_BUF, m_tx, 8'hff);
      $display("test slave byte done");
      // stream paced by an unread receive buffer stops after two bytes
      wr(SFR_CFG_TWO, 8'h80);
      wr(SFR_CFG_ONE, 8'h50);
      wr(SFR_TX_BUF, rnd());
      wait_ss(1'b0);
      wr(SFR_TX_BUF, rnd());
      repeat (70) @(negedge clk);
      wr(SFR_TX_BUF, rnd());
      wait_ss(1'b1);
      cmp("paced stop", 8'h01, {7'h0, waited < 100});
      wait_ss(1'b0);
      wait_ss(1'b1);
      rd(SFR_STATUS, 8'h30, 8'h30);
      $display("test receive pacing done");
      // another master pulls the select input low mid-byte
      wr(SFR_CFG_ONE, 8'h48);
      wr(SFR_TX_BUF, rnd());
      repeat (20) @(negedge clk);
      tb_ss_n = 1'b0;
      repeat (80) @(negedge clk);
      tb_ss_n = 1'b1;
      rd(SFR_STATUS, 8'h40, 8'h40);
      wr(SFR_STATUS, 8'hbf);
      rd(SFR_STATUS, 8'h00, 8'h40);
      $display("test multimaster error done");
      repeat (4) @(negedge clk);
      end_of_test();
   end
endmodule : sms_spi_port_tb
